// ---- rtl/lcdd_driver.sv ----
// serial capture, display latch and backplane/frontplane drive sequencing
// Operation
// - capture runs from serial pins, drive runs from oscillator, independently
// - each accepted serial clock except the skipped 129th shifts one data bit into 128-bit register
// - the 128 bits form four 32-bit groups, one per backplane
// - exactly one backplane active at a time, stepping through all four
// - frontplanes switch to the matching group when its backplane turns active
// - a one turns a plane driver on, a zero turns it off
// - active backplane steps full then zero; inactive steps third then two thirds
// - on frontplane steps zero then full; off steps two thirds then third
// - after each level change, high-current drive holds four oscillator periods
// - address pins select this chip; other addresses are ignored
// - latch-control pin may set the instant data goes to display
// - latch-control held high latches automatically after every 128 bits
// - address is 0111, three pin levels, then one ignored bit
// - start condition then 8-bit address, then one data bit per clock
// - latch pin high pulse while serial clock high latches shifted data
// - after 128 bits the 129th clock is skipped, 130th resumes data
`timescale 1ns/1ps
`default_nettype none

module lcdd_driver (
    input  wire logic                clk,                // 125 MHz system clock
    input  wire logic                srst,               // synchronous reset, active high
    input  wire logic                serial_bit_clock,   // host serial clock pin
    input  wire logic                serial_data_in,     // host serial data pin
    input  wire logic                latch_control_pin,  // latch control pin
    input  wire logic                addr_select_bit0,   // address strap bit 0
    input  wire logic                addr_select_bit1,   // address strap bit 1
    input  wire logic                addr_select_bit2,   // address strap bit 2
    input  wire logic                oscillator_input,   // drive-section timebase
    output lcdd_pkg::lcdd_drive_t    lcd_drive_q         // plane levels and current mode
);

    lcdd_pkg::lcdd_pins_t      pins_raw;
    lcdd_pkg::lcdd_pins_t      sync1_q;
    lcdd_pkg::lcdd_pins_t      sync2_q;
    lcdd_pkg::lcdd_pins_t      prev_q;
    lcdd_pkg::lcdd_cap_state_t state_q;
    logic [lcdd_pkg::ADDR_BITS-1:0]  addr_sh_q;
    logic [7:0]                      bit_cnt_q;
    logic [lcdd_pkg::SHIFT_BITS-1:0] shift_q;
    logic [lcdd_pkg::SHIFT_BITS-1:0] disp_q;
    logic [6:0]                      phase_cnt_q;
    logic                            phase_q;
    logic [1:0]                      bp_idx_q;
    logic [2:0]                      hc_cnt_q;
    lcdd_pkg::lcdd_drive_t           drive_d;

    logic sclk_rise;
    logic start_c;
    logic stop_c;
    logic latch_rise;
    logic osc_rise;
    logic data_edge;
    logic level_change;
    logic [lcdd_pkg::ADDR_BITS-1:0] addr_full;

    function automatic logic addr_match(input logic [7:0] a, input logic [2:0] straps);
        addr_match = (a[7:4] == lcdd_pkg::ADDR_PREFIX) && (a[3:1] == straps);
    endfunction : addr_match

    function automatic logic [31:0] group_of(input logic [127:0] d, input logic [1:0] idx);
        logic [31:0] g;
        g = '0;
        for (int k = 0; k < lcdd_pkg::NUM_BP; k++) begin
            if (2'(k) == idx) begin
                g = d[lcdd_pkg::SHIFT_BITS-1-lcdd_pkg::GROUP_BITS*k -: lcdd_pkg::GROUP_BITS];
            end
        end
        group_of = g;
    endfunction : group_of

    assign pins_raw = '{sclk: serial_bit_clock, sdat: serial_data_in,
                        latch: latch_control_pin,
                        addr: {addr_select_bit2, addr_select_bit1, addr_select_bit0},
                        osc: oscillator_input};

    // two-flop synchroniser for every pin; free running through reset so the
    // edge history already matches the idle pins and no false edge follows it
    always_ff @(posedge clk) begin
        sync1_q <= pins_raw;
        sync2_q <= sync1_q;
        prev_q  <= sync2_q;
    end

    // edges and bus conditions seen on synchronised pins
    assign sclk_rise  = sync2_q.sclk & ~prev_q.sclk;
    assign start_c    = sync2_q.sclk & prev_q.sclk & prev_q.sdat & ~sync2_q.sdat;
    assign stop_c     = sync2_q.sclk & prev_q.sclk & ~prev_q.sdat & sync2_q.sdat;
    assign latch_rise = sync2_q.latch & ~prev_q.latch & sync2_q.sclk;
    assign osc_rise   = sync2_q.osc & ~prev_q.osc;
    assign addr_full  = {addr_sh_q[lcdd_pkg::ADDR_BITS-2:0], sync2_q.sdat};
    assign data_edge  = (state_q == lcdd_pkg::CAP_DATA) && sclk_rise && !start_c && !stop_c;

    // capture state: start, address, data
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= lcdd_pkg::CAP_IDLE;
        end else if (start_c) begin
            state_q <= lcdd_pkg::CAP_ADDR;
        end else if (stop_c) begin
            state_q <= lcdd_pkg::CAP_IDLE;
        end else begin
            case (state_q)
                lcdd_pkg::CAP_ADDR: begin
                    if (sclk_rise && bit_cnt_q[2:0] == lcdd_pkg::ADDR_LAST_IDX) begin
                        state_q <= addr_match(addr_full, sync2_q.addr)
                                   ? lcdd_pkg::CAP_DATA : lcdd_pkg::CAP_IDLE;
                    end
                end
                lcdd_pkg::CAP_DATA: state_q <= lcdd_pkg::CAP_DATA;
                lcdd_pkg::CAP_IDLE: state_q <= lcdd_pkg::CAP_IDLE;
                default:            state_q <= lcdd_pkg::CAP_IDLE;
            endcase
        end
    end

    // address shifter
    always_ff @(posedge clk) begin
        if (srst || start_c) begin
            addr_sh_q <= '0;
        end else if (state_q == lcdd_pkg::CAP_ADDR && sclk_rise) begin
            addr_sh_q <= addr_full;
        end
    end

    // bit counter: address bits, then data bits with the skipped 129th edge
    always_ff @(posedge clk) begin
        if (srst || start_c || stop_c) begin
            bit_cnt_q <= '0;
        end else if (state_q == lcdd_pkg::CAP_ADDR && sclk_rise) begin
            bit_cnt_q <= (bit_cnt_q[2:0] == lcdd_pkg::ADDR_LAST_IDX) ? 8'h00 : bit_cnt_q + 8'h01;
        end else if (data_edge) begin
            bit_cnt_q <= (bit_cnt_q == lcdd_pkg::CNT_SKIP) ? 8'h00 : bit_cnt_q + 8'h01;
        end
    end

    // data shift register
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_q <= '0;
        end else if (data_edge && bit_cnt_q != lcdd_pkg::CNT_SKIP) begin
            shift_q <= {shift_q[lcdd_pkg::SHIFT_BITS-2:0], sync2_q.sdat};
        end
    end

    // display latch, separate from the shift register
    always_ff @(posedge clk) begin
        if (srst) begin
            disp_q <= '0;
        end else if (data_edge && bit_cnt_q == lcdd_pkg::CNT_LAST_BIT && sync2_q.latch) begin
            disp_q <= {shift_q[lcdd_pkg::SHIFT_BITS-2:0], sync2_q.sdat};
        end else if (latch_rise) begin
            disp_q <= shift_q;
        end
    end

    assign level_change = osc_rise && (phase_cnt_q == lcdd_pkg::PHASE_LAST);

    // oscillator-driven phase and backplane sequencing
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_cnt_q <= '0;
            phase_q     <= 1'b0;
            bp_idx_q    <= '0;
        end else if (osc_rise) begin
            if (level_change) begin
                phase_cnt_q <= '0;
                phase_q     <= ~phase_q;
                if (phase_q) begin
                    bp_idx_q <= bp_idx_q + 2'h1;
                end
            end else begin
                phase_cnt_q <= phase_cnt_q + 7'h01;
            end
        end
    end

    // high-current window after each level step
    always_ff @(posedge clk) begin
        if (srst) begin
            hc_cnt_q <= '0;
        end else if (level_change) begin
            hc_cnt_q <= lcdd_pkg::HC_LOAD;
        end else if (osc_rise && hc_cnt_q != 3'h0) begin
            hc_cnt_q <= hc_cnt_q - 3'h1;
        end
    end

    // plane level formatting
    always_comb begin
        logic [31:0] grp;
        grp = group_of(disp_q, bp_idx_q);
        drive_d = '0;
        for (int b = 0; b < lcdd_pkg::NUM_BP; b++) begin
            if (2'(b) == bp_idx_q) begin
                drive_d.bp[b] = phase_q ? lcdd_pkg::LVL_ZERO : lcdd_pkg::LVL_FULL;
            end else begin
                drive_d.bp[b] = phase_q ? lcdd_pkg::LVL_TWO_THIRD : lcdd_pkg::LVL_THIRD;
            end
        end
        for (int f = 0; f < lcdd_pkg::GROUP_BITS; f++) begin
            if (grp[f]) begin
                drive_d.fp[f] = phase_q ? lcdd_pkg::LVL_FULL : lcdd_pkg::LVL_ZERO;
            end else begin
                drive_d.fp[f] = phase_q ? lcdd_pkg::LVL_THIRD : lcdd_pkg::LVL_TWO_THIRD;
            end
        end
        drive_d.high_current = (hc_cnt_q != 3'h0);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lcd_drive_q <= '0;
        end else begin
            lcd_drive_q <= drive_d;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic [lcdd_pkg::GROUP_BITS-1:0] grp_now;
    assign grp_now = group_of(disp_q, bp_idx_q);

    logic [3:0] bp_act;
    always_comb begin
        for (int b = 0; b < lcdd_pkg::NUM_BP; b++) begin
            bp_act[b] = (lcd_drive_q.bp[b] == lcdd_pkg::LVL_FULL)
                     || (lcd_drive_q.bp[b] == lcdd_pkg::LVL_ZERO);
        end
    end

    sequence s_phase_end;
        level_change && phase_q;
    endsequence

    sequence s_addr_last;
        state_q == lcdd_pkg::CAP_ADDR && sclk_rise && !start_c && !stop_c
            && bit_cnt_q[2:0] == lcdd_pkg::ADDR_LAST_IDX;
    endsequence

    property p_one_bp;
        $onehot(bp_act) || $past(srst);
    endproperty
    a_one_bp: assert property (p_one_bp) else $error("backplane activity not one-hot");

    property p_bp_step;
        s_phase_end |=> bp_idx_q == $past(bp_idx_q) + 2'h1;
    endproperty
    a_bp_step: assert property (p_bp_step) else $error("backplane did not advance");

    property p_hc_hold;
        level_change |=> ##1 lcd_drive_q.high_current [*4];
    endproperty
    a_hc_hold: assert property (p_hc_hold) else $error("high current not held");

    property p_hc_off;
        hc_cnt_q == 3'h0 && !level_change |=> ##1 !lcd_drive_q.high_current;
    endproperty
    a_hc_off: assert property (p_hc_off) else $error("high current stuck on");

    property p_addr_bad;
        s_addr_last and !addr_match(addr_full, sync2_q.addr) |=> state_q == lcdd_pkg::CAP_IDLE;
    endproperty
    a_addr_bad: assert property (p_addr_bad) else $error("foreign address accepted");

    property p_addr_ok;
        s_addr_last and addr_match(addr_full, sync2_q.addr) |=> state_q == lcdd_pkg::CAP_DATA;
    endproperty
    a_addr_ok: assert property (p_addr_ok) else $error("own address rejected");

    property p_start;
        start_c |=> state_q == lcdd_pkg::CAP_ADDR && bit_cnt_q == 8'h00;
    endproperty
    a_start: assert property (p_start) else $error("start not honoured");

    property p_skip;
        data_edge && bit_cnt_q == lcdd_pkg::CNT_SKIP |=> $stable(shift_q) && bit_cnt_q == 8'h00;
    endproperty
    a_skip: assert property (p_skip) else $error("129th clock not skipped");

    property p_shift;
        data_edge && bit_cnt_q != lcdd_pkg::CNT_SKIP
            |=> shift_q[0] == $past(sync2_q.sdat) && shift_q[127:1] == $past(shift_q[126:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("data bit not shifted");

    property p_auto_latch;
        data_edge && bit_cnt_q == lcdd_pkg::CNT_LAST_BIT && sync2_q.latch |=> disp_q == shift_q;
    endproperty
    a_auto_latch: assert property (p_auto_latch) else $error("auto latch missed");

    property p_ext_latch;
        latch_rise && !data_edge |=> disp_q == $past(shift_q);
    endproperty
    a_ext_latch: assert property (p_ext_latch) else $error("external latch missed");

    property p_disp_hold;
        !latch_rise && !data_edge |=> $stable(disp_q);
    endproperty
    a_disp_hold: assert property (p_disp_hold) else $error("display changed unlatched");

    property p_fp_level;
        phase_q && grp_now[0] && !osc_rise
            |=> lcd_drive_q.fp[0] == lcdd_pkg::LVL_FULL;
    endproperty
    a_fp_level: assert property (p_fp_level) else $error("frontplane on level wrong");

endmodule : lcdd_driver

`default_nettype wire

// ---- rtl/lcdd_pkg.sv ----
// shared constants and carrier types for the four-way multiplexed segment driver
package lcdd_pkg;
    localparam int SHIFT_BITS  = 128;
    localparam int GROUP_BITS  = 32;
    localparam int NUM_BP      = 4;
    localparam int ADDR_BITS   = 8;
    localparam int PHASE_OSC   = 125;
    localparam int HC_OSC      = 4;
    localparam logic [3:0] ADDR_PREFIX = 4'h7;
    localparam logic [2:0] ADDR_LAST_IDX = 3'h7;
    localparam logic [7:0] CNT_LAST_BIT  = 8'h7F;
    localparam logic [7:0] CNT_SKIP      = 8'h80;
    localparam logic [6:0] PHASE_LAST    = 7'(PHASE_OSC - 1);
    localparam logic [2:0] HC_LOAD       = 3'(HC_OSC);
    localparam logic [1:0] LVL_ZERO      = 2'h0;
    localparam logic [1:0] LVL_THIRD     = 2'h1;
    localparam logic [1:0] LVL_TWO_THIRD = 2'h2;
    localparam logic [1:0] LVL_FULL      = 2'h3;

    typedef enum logic [1:0] {CAP_IDLE, CAP_ADDR, CAP_DATA} lcdd_cap_state_t;

    typedef struct packed {
        logic       sclk;
        logic       sdat;
        logic       latch;
        logic [2:0] addr;
        logic       osc;
    } lcdd_pins_t;

    typedef struct packed {
        logic [NUM_BP-1:0][1:0]     bp;
        logic [GROUP_BITS-1:0][1:0] fp;
        logic                       high_current;
    } lcdd_drive_t;
endpackage : lcdd_pkg

// ---- test/lcdd_host_model.sv ----
// host-side model driving the serial clock, data and latch pins
`timescale 1ns/1ps
`default_nettype none

module lcdd_host_model (
    input  wire logic clk,    // bench clock used only for pacing
    output var  logic sclk,   // serial clock, idle high
    output var  logic sdat,   // serial data, idle high
    output var  logic latch   // latch control level
);
    initial begin
        sclk = 1'b1;
        sdat = 1'b1;
        latch = 1'b1;
    end

    // half of the 80 ns link clock period
    task automatic half();
        repeat (5) @(posedge clk);
        #1;
    endtask : half

    task automatic set_latch(input logic v);
        latch = v;
        half();
    endtask : set_latch

    // data falls while the clock is high, from idle
    task automatic start();
        sdat = 1'b0;
        half();
    endtask : start

    // data changes only while the clock is low
    task automatic send_bit(input logic b);
        sclk = 1'b0;
        sdat = b;
        half();
        sclk = 1'b1;
        half();
    endtask : send_bit

    task automatic send_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) send_bit(v[i]);
    endtask : send_byte

    task automatic send_blk(input logic [127:0] v);
        for (int i = 127; i >= 0; i--) send_bit(v[i]);
    endtask : send_blk

    task automatic stop();
        sclk = 1'b0;
        sdat = 1'b0;
        half();
        sclk = 1'b1;
        half();
        sdat = 1'b1;
        half();
    endtask : stop

    // one high pulse while the serial clock rests high
    task automatic pulse();
        latch = 1'b1;
        half();
        latch = 1'b0;
        half();
    endtask : pulse
endmodule : lcdd_host_model

`default_nettype wire

// ---- test/tb_lcdd_driver.sv ----
// self-checking bench for the segment driver
`timescale 1ns/1ps
`default_nettype none

module tb_lcdd_driver;
    localparam logic [127:0] PAT_A = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    localparam logic [127:0] PAT_B = 128'h8000_0001_5555_AAAA_FFFF_0000_0F0F_F0F0;
    localparam logic [127:0] PAT_C = 128'h1357_9BDF_0246_8ACE_C3C3_3C3C_A5A5_0000;

    logic                  clk;
    logic                  srst;
    logic                  osc;
    logic [2:0]            straps;
    logic                  sclk;
    logic                  sdat;
    logic                  latch;
    lcdd_pkg::lcdd_drive_t drv;
    int                    n_errors;
    int                    checks;
    int                    cyc;

    lcdd_host_model host_i (.clk(clk), .sclk(sclk), .sdat(sdat), .latch(latch));

    lcdd_driver lcdd_driver_i (
        .clk(clk), .srst(srst), .serial_bit_clock(sclk), .serial_data_in(sdat),
        .latch_control_pin(latch), .addr_select_bit0(straps[0]),
        .addr_select_bit1(straps[1]), .addr_select_bit2(straps[2]),
        .oscillator_input(osc), .lcd_drive_q(drv)
    );

    initial clk = 1'b0;
    always #4 clk = ~clk;

    // drive timebase, 48 ns period, unrelated to the serial link
    always begin
        repeat (3) @(posedge clk);
        #1;
        osc = ~osc;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic check(input logic [136:0] seen, input logic [136:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task automatic wait_bp(input int k, input logic [1:0] lvl);
        int i;
        i = 0;
        while (drv.bp[k] !== lvl && i < 8000) begin
            @(posedge clk);
            #1;
            i++;
        end
        if (i == 8000) check(137'(drv.bp[k]), 137'(lvl));
    endtask : wait_bp

    // follow one full frame from bp0 and compare every phase with v
    task automatic chk_disp(input logic [127:0] v);
        logic [31:0][1:0] f1;
        logic [31:0][1:0] f2;
        logic [3:0][1:0]  b1;
        logic [3:0][1:0]  b2;
        wait_bp(0, 2'h1);
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 4; i++) begin
                b1[i] = (i == k) ? 2'h3 : 2'h1;
                b2[i] = (i == k) ? 2'h0 : 2'h2;
            end
            for (int j = 0; j < 32; j++) begin
                f1[j] = v[96 - 32 * k + j] ? 2'h0 : 2'h2;
                f2[j] = v[96 - 32 * k + j] ? 2'h3 : 2'h1;
            end
            wait_bp(k, 2'h3);
            check(137'(drv.bp), 137'(b1));
            check(137'(drv.fp), 137'(f1));
            check(137'(drv.high_current), 137'(1'b1));
            wait_bp(k, 2'h0);
            check(137'(drv.bp), 137'(b2));
            check(137'(drv.fp), 137'(f2));
            check(137'(drv.high_current), 137'(1'b1));
            repeat (32) @(posedge clk);
            #1;
            check(137'(drv.high_current), 137'(1'b0));
        end
    endtask : chk_disp

    // auto latch after 128 bits, then an open channel skipping bit 129
    task automatic s_auto();
        host_i.start();
        host_i.send_byte(8'h7A);
        host_i.send_blk(PAT_A);
        chk_disp(PAT_A);
        host_i.send_bit(1'b1);
        host_i.send_blk(PAT_B);
        host_i.stop();
        chk_disp(PAT_B);
    endtask : s_auto

    // transfer to another strap setting leaves the display alone
    task automatic s_bad_addr();
        host_i.start();
        host_i.send_byte(8'h74);
        host_i.send_blk(PAT_C);
        host_i.stop();
        chk_disp(PAT_B);
    endtask : s_bad_addr

    // external latch: shifting alone must not reach the segments
    task automatic s_ext_latch();
        host_i.set_latch(1'b0);
        host_i.start();
        host_i.send_byte(8'h7B);
        host_i.send_blk(PAT_C);
        host_i.stop();
        chk_disp(PAT_B);
        host_i.pulse();
        chk_disp(PAT_C);
    endtask : s_ext_latch

    initial begin
        n_errors = 0;
        checks = 0;
        cyc = 0;
        srst = 1'b1;
        osc = 1'b0;
        straps = 3'h5;
        repeat (5) @(posedge clk);
        #1;
        check(137'(drv), 137'h0);
        @(posedge clk);
        #1;
        srst = 1'b0;
        s_auto();
        s_bad_addr();
        s_ext_latch();
        stop_test();
    end
endmodule : tb_lcdd_driver

`default_nettype wire
